/* lhb_pkg.sv */
package lhb_pkg;

  typedef enum logic [2:0] {
    LHB_I80_8   = 3'h0,
    LHB_I80_4   = 3'h1,
    LHB_M68_8   = 3'h2,
    LHB_M68_4   = 3'h3,
    LHB_SER4    = 3'h4,
    LHB_SER3    = 3'h5,
    LHB_I2C     = 3'h6,
    LHB_BADMODE = 3'h7
  } lhb_mode_t;

  // command/data select levels for a command byte and a data byte
  localparam logic       CD_CMD          = 1'h0;
  localparam logic       CD_DATA         = 1'h1;

  localparam logic [7:0] CMD_TEMP_COMP   = 8'h24;
  localparam logic [7:0] CMD_PANEL_LOAD  = 8'h2B;
  localparam logic [7:0] CMD_PUMP_CTRL   = 8'h2F;
  localparam logic [7:0] CMD_MAPPING     = 8'hC0;
  localparam logic [7:0] ARG_MAPPING     = 8'h04;
  localparam logic [7:0] CMD_LINE_INV    = 8'hC8;
  localparam logic [7:0] ARG_LINE_INV    = 8'h08;
  localparam logic [7:0] CMD_BIAS        = 8'hEA;
  localparam logic [7:0] CMD_CONTRAST    = 8'h81;
  localparam logic [7:0] CONTRAST_REF    = 8'hDC;
  localparam logic [7:0] CMD_DISP_ENABLE = 8'hA9;
  localparam logic [7:0] CMD_DISP_PATT   = 8'hD1;
  localparam logic [7:0] CMD_SYS_RESET   = 8'hE2;

  // opcode prefixes of the single-byte field commands
  localparam logic [5:0] OP_TEMP_COMP    = 6'h09;
  localparam logic [5:0] OP_PANEL_LOAD   = 6'h0A;
  localparam logic [5:0] OP_PUMP_CTRL    = 6'h0B;
  localparam logic [5:0] OP_BIAS         = 6'h3A;
  localparam logic [4:0] OP_DISP_ENABLE  = 5'h15;
  localparam logic [4:0] OP_DISP_PATT    = 5'h1A;

  localparam logic [1:0] RST_TEMP_COMP   = 2'h0;
  localparam logic [3:0] RST_PUMP_PANEL  = 4'h0;
  localparam logic [2:0] RST_MAPPING     = 3'h0;
  localparam logic [6:0] RST_LINE_INV    = 7'h00;
  localparam logic [1:0] RST_BIAS        = 2'h2;
  localparam logic [7:0] RST_CONTRAST    = 8'h00;
  localparam logic [5:0] RST_DISP_CTL    = 6'h00;

  localparam int         INIT_LEN        = 12;
  localparam int         CLK_MHZ         = 250;
  localparam int         INIT_WAIT_MS    = 150;
  localparam int         OFF_WAIT_MS     = 2;
  localparam int         INIT_WAIT_CYC   = INIT_WAIT_MS * 1000 * CLK_MHZ;
  localparam int         OFF_WAIT_CYC    = OFF_WAIT_MS * 1000 * CLK_MHZ;
  localparam int         PHASE_CYC       = 4;
  localparam int         RST_PULSE_CYC   = 16;

  function automatic lhb_mode_t decode_mode(input logic       style,
                                            input logic [1:0] width);
    case ({style, width})
      3'h0:    decode_mode = LHB_I80_8;
      3'h1:    decode_mode = LHB_I80_4;
      3'h4:    decode_mode = LHB_M68_8;
      3'h5:    decode_mode = LHB_M68_4;
      3'h2:    decode_mode = LHB_SER4;
      3'h6:    decode_mode = LHB_SER3;
      3'h7:    decode_mode = LHB_I2C;
      default: decode_mode = LHB_BADMODE;
    endcase
  endfunction

endpackage

/* lhb_if.sv */
`timescale 1ns/1ps
interface lhb_if;
  logic       bus_style_strap;
  logic [1:0] width_strap;
  logic       chip_select_primary_n;
  logic       command_data_select;
  logic       write_strobe_pin;
  logic       read_strobe_pin;
  logic [7:0] data_bus;
  logic       reset_pin_n;

  modport host (
    output bus_style_strap,
    output width_strap,
    output chip_select_primary_n,
    output command_data_select,
    output write_strobe_pin,
    output read_strobe_pin,
    output data_bus,
    output reset_pin_n
  );

  modport device (
    input bus_style_strap,
    input width_strap,
    input chip_select_primary_n,
    input command_data_select,
    input write_strobe_pin,
    input read_strobe_pin,
    input data_bus,
    input reset_pin_n
  );
endinterface

/* lhb_device.sv */
`timescale 1ns/1ps
module lhb_device (
  input  wire logic              mclk,
  input  wire logic              reset,
  lhb_if.device                  bus,
  output lhb_pkg::lhb_mode_t     mode,
  output logic                   mode_ok,
  output logic [1:0]             temp_comp_field,
  output logic [3:0]             pump_panel_field,
  output logic [2:0]             mapping_field,
  output logic [6:0]             line_inversion_field,
  output logic [1:0]             bias_ratio_field,
  output logic [7:0]             contrast_level_field,
  output logic [5:0]             display_control_field,
  output logic [7:0]             disp_data,
  output logic                   disp_valid
);

  typedef enum logic [1:0] {
    PD_NONE = 2'h0,
    PD_MAP  = 2'h1,
    PD_NIV  = 2'h2,
    PD_PM   = 2'h3
  } lhb_pend_t;

  lhb_pkg::lhb_mode_t mode_r;
  lhb_pend_t  pend_r;
  logic       sys_rst;
  logic       cmd_rst_r;
  logic       cs_on;
  logic       wr_q_r;
  logic       rd_q_r;
  logic       sck_q_r;
  logic       unit_ev;
  logic       nib_hi_r;
  logic [3:0] hi_r;
  logic [6:0] shift_r;
  logic [2:0] bits_r;
  logic       byte_vld_r;
  logic [7:0] byte_r;
  logic       byte_cd_r;

  // internal power-on reset, the reset pin, or the reset command
  assign sys_rst = reset | ~bus.reset_pin_n | cmd_rst_r;
  // second select is tied active inside the module
  assign cs_on = ~bus.chip_select_primary_n;

  always_comb begin
    case (mode_r)
      lhb_pkg::LHB_I80_8, lhb_pkg::LHB_I80_4:
        unit_ev = cs_on & ~wr_q_r & bus.write_strobe_pin;
      lhb_pkg::LHB_M68_8, lhb_pkg::LHB_M68_4:
        unit_ev = cs_on & rd_q_r & ~bus.read_strobe_pin
                  & ~bus.write_strobe_pin;
      lhb_pkg::LHB_SER4:
        unit_ev = cs_on & ~sck_q_r & bus.data_bus[0];
      default:
        unit_ev = 1'h0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      mode_r <= lhb_pkg::LHB_BADMODE;
      wr_q_r <= 1'h1;
      rd_q_r <= 1'h0;
      sck_q_r <= 1'h0;
    end else begin
      mode_r <= lhb_pkg::decode_mode(bus.bus_style_strap,
                                     bus.width_strap);
      wr_q_r <= bus.write_strobe_pin;
      rd_q_r <= bus.read_strobe_pin;
      sck_q_r <= bus.data_bus[0];
    end
  end

  // byte assembly; a deselect drops any half-received byte
  always_ff @(posedge mclk) begin
    if (sys_rst || !cs_on) begin
      nib_hi_r <= 1'h0;
      hi_r <= 4'h0;
      shift_r <= 7'h00;
      bits_r <= 3'h0;
      byte_vld_r <= 1'h0;
      byte_r <= 8'h00;
      byte_cd_r <= lhb_pkg::CD_CMD;
    end else begin
      byte_vld_r <= 1'h0;
      if (unit_ev) begin
        case (mode_r)
          lhb_pkg::LHB_I80_4, lhb_pkg::LHB_M68_4: begin
            nib_hi_r <= ~nib_hi_r;
            hi_r <= bus.data_bus[3:0];
            if (nib_hi_r) begin
              byte_vld_r <= 1'h1;
              byte_r <= {hi_r, bus.data_bus[3:0]};
              byte_cd_r <= bus.command_data_select;
            end
          end
          lhb_pkg::LHB_SER4: begin
            shift_r <= {shift_r[5:0], bus.data_bus[3]};
            bits_r <= bits_r + 3'h1;
            if (bits_r == 3'h7) begin
              byte_vld_r <= 1'h1;
              byte_r <= {shift_r, bus.data_bus[3]};
              byte_cd_r <= bus.command_data_select;
            end
          end
          default: begin
            byte_vld_r <= 1'h1;
            byte_r <= bus.data_bus;
            byte_cd_r <= bus.command_data_select;
          end
        endcase
      end
    end
  end

  // command interpreter
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pend_r <= PD_NONE;
      cmd_rst_r <= 1'h0;
      temp_comp_field <= lhb_pkg::RST_TEMP_COMP;
      pump_panel_field <= lhb_pkg::RST_PUMP_PANEL;
      mapping_field <= lhb_pkg::RST_MAPPING;
      line_inversion_field <= lhb_pkg::RST_LINE_INV;
      bias_ratio_field <= lhb_pkg::RST_BIAS;
      contrast_level_field <= lhb_pkg::RST_CONTRAST;
      display_control_field <= lhb_pkg::RST_DISP_CTL;
      disp_data <= 8'h00;
      disp_valid <= 1'h0;
    end else begin
      disp_valid <= 1'h0;
      if (byte_vld_r && byte_cd_r == lhb_pkg::CD_DATA) begin
        disp_data <= byte_r;
        disp_valid <= 1'h1;
      end else if (byte_vld_r && pend_r != PD_NONE) begin
        // argument byte follows its opcode directly
        pend_r <= PD_NONE;
        case (pend_r)
          PD_MAP:  mapping_field <= byte_r[2:0];
          PD_NIV:  line_inversion_field <= byte_r[6:0];
          PD_PM:   contrast_level_field <= byte_r;
          default: pend_r <= PD_NONE;
        endcase
      end else if (byte_vld_r) begin
        if (byte_r == lhb_pkg::CMD_MAPPING)
          pend_r <= PD_MAP;
        else if (byte_r == lhb_pkg::CMD_LINE_INV)
          pend_r <= PD_NIV;
        else if (byte_r == lhb_pkg::CMD_CONTRAST)
          pend_r <= PD_PM;
        else if (byte_r == lhb_pkg::CMD_SYS_RESET)
          cmd_rst_r <= 1'h1;
        else if (byte_r[7:2] == lhb_pkg::OP_TEMP_COMP)
          // field sits one bit up, so the 24H opcode yields 10b
          temp_comp_field <= byte_r[2:1];
        else if (byte_r[7:2] == lhb_pkg::OP_PANEL_LOAD)
          pump_panel_field[1:0] <= byte_r[1:0];
        else if (byte_r[7:2] == lhb_pkg::OP_PUMP_CTRL)
          pump_panel_field[3:2] <= byte_r[1:0];
        else if (byte_r[7:2] == lhb_pkg::OP_BIAS)
          bias_ratio_field <= byte_r[1:0];
        else if (byte_r[7:3] == lhb_pkg::OP_DISP_ENABLE)
          display_control_field[2:0] <= byte_r[2:0];
        else if (byte_r[7:3] == lhb_pkg::OP_DISP_PATT)
          display_control_field[5:3] <= byte_r[2:0];
      end
    end
  end

  assign mode = mode_r;
  // 3-wire and two-wire buses are recognised but not decoded
  assign mode_ok = (mode_r <= lhb_pkg::LHB_SER4);

endmodule

/* lhb_host.sv */
`timescale 1ns/1ps
module lhb_host #(
  parameter int INIT_WAIT_CYC = lhb_pkg::INIT_WAIT_CYC,
  parameter int OFF_WAIT_CYC  = lhb_pkg::OFF_WAIT_CYC
) (
  input  wire logic       mclk,
  input  wire logic       reset,
  lhb_if.host             bus,
  input  wire logic       style_sel,
  input  wire logic [1:0] width_sel,
  input  wire logic [7:0] contrast_level,
  input  wire logic       wr_valid,
  input  wire logic [7:0] wr_data,
  output logic            wr_ready,
  input  wire logic       power_down_req,
  output logic            init_done,
  output logic            power_off_ok
);

  typedef enum logic [2:0] {
    HS_RST      = 3'h0,
    HS_WAIT     = 3'h1,
    HS_INIT     = 3'h2,
    HS_READY    = 3'h3,
    HS_OFF_CMD  = 3'h4,
    HS_OFF_WAIT = 3'h5,
    HS_OFF      = 3'h6
  } lhb_hstate_t;

  typedef enum logic [1:0] {
    E_IDLE = 2'h0,
    E_LO   = 2'h1,
    E_HI   = 2'h2,
    E_END  = 2'h3
  } lhb_estate_t;

  lhb_hstate_t        st_r;
  lhb_estate_t        eng_r;
  lhb_pkg::lhb_mode_t mode;
  logic        style_r;
  logic [1:0]  width_r;
  logic [31:0] cnt_r;
  logic [3:0]  idx_r;
  logic        go_r;
  logic [7:0]  go_byte_r;
  logic        go_cd_r;
  logic        eng_free;
  logic [7:0]  sh_r;
  logic [2:0]  unit_r;
  logic [2:0]  last_unit;
  logic [1:0]  ph_r;
  logic        ph_end;
  logic        active;
  logic        cd_r;
  logic        rst_pin_n_r;
  logic        cs_n_nxt;
  logic        wr_nxt;
  logic        rd_nxt;
  logic [7:0]  data_nxt;
  logic        cs_n_r;
  logic        wr_pin_r;
  logic        rd_pin_r;
  logic [7:0]  data_r;

  // fixed list; contrast comes from a port for per-lot trimming
  function automatic logic [7:0] init_byte(input logic [3:0] idx,
                                           input logic [7:0] pm);
    case (idx)
      4'h0:    init_byte = lhb_pkg::CMD_TEMP_COMP;
      4'h1:    init_byte = lhb_pkg::CMD_PANEL_LOAD;
      4'h2:    init_byte = lhb_pkg::CMD_PUMP_CTRL;
      4'h3:    init_byte = lhb_pkg::CMD_MAPPING;
      4'h4:    init_byte = lhb_pkg::ARG_MAPPING;
      4'h5:    init_byte = lhb_pkg::CMD_LINE_INV;
      4'h6:    init_byte = lhb_pkg::ARG_LINE_INV;
      4'h7:    init_byte = lhb_pkg::CMD_BIAS;
      4'h8:    init_byte = lhb_pkg::CMD_CONTRAST;
      4'h9:    init_byte = pm;
      4'hA:    init_byte = lhb_pkg::CMD_DISP_ENABLE;
      default: init_byte = lhb_pkg::CMD_DISP_PATT;
    endcase
  endfunction

  assign mode = lhb_pkg::decode_mode(style_r, width_r);
  assign eng_free = (eng_r == E_IDLE) && !go_r;
  assign ph_end = (ph_r == 2'(lhb_pkg::PHASE_CYC - 1));
  assign active = (eng_r == E_HI);

  always_comb begin
    case (mode)
      lhb_pkg::LHB_I80_4, lhb_pkg::LHB_M68_4: last_unit = 3'h1;
      lhb_pkg::LHB_SER4:                      last_unit = 3'h7;
      default:                                last_unit = 3'h0;
    endcase
  end

  // sequencer
  always_ff @(posedge mclk) begin
    if (reset) begin
      st_r <= HS_RST;
      cnt_r <= 32'(lhb_pkg::RST_PULSE_CYC - 1);
      idx_r <= 4'h0;
      go_r <= 1'h0;
      go_byte_r <= 8'h00;
      go_cd_r <= lhb_pkg::CD_CMD;
      rst_pin_n_r <= 1'h0;
    end else begin
      go_r <= 1'h0;
      case (st_r)
        HS_RST: begin
          if (cnt_r == 32'h0) begin
            rst_pin_n_r <= 1'h1;
            cnt_r <= 32'(INIT_WAIT_CYC - 1);
            st_r <= HS_WAIT;
          end else begin
            cnt_r <= cnt_r - 32'h1;
          end
        end
        HS_WAIT: begin
          if (cnt_r == 32'h0)
            st_r <= HS_INIT;
          else
            cnt_r <= cnt_r - 32'h1;
        end
        HS_INIT: begin
          // each byte starts two idle cycles after the last one ends
          if (eng_free && idx_r == 4'(lhb_pkg::INIT_LEN)) begin
            st_r <= HS_READY;
          end else if (eng_free) begin
            go_r <= 1'h1;
            go_byte_r <= init_byte(idx_r, contrast_level);
            go_cd_r <= lhb_pkg::CD_CMD;
            idx_r <= idx_r + 4'h1;
          end
        end
        HS_READY: begin
          if (power_down_req && eng_free) begin
            go_r <= 1'h1;
            go_byte_r <= lhb_pkg::CMD_SYS_RESET;
            go_cd_r <= lhb_pkg::CD_CMD;
            st_r <= HS_OFF_CMD;
          end else if (wr_valid && eng_free) begin
            go_r <= 1'h1;
            go_byte_r <= wr_data;
            go_cd_r <= lhb_pkg::CD_DATA;
          end
        end
        HS_OFF_CMD: begin
          if (eng_free) begin
            cnt_r <= 32'(OFF_WAIT_CYC - 1);
            st_r <= HS_OFF_WAIT;
          end
        end
        HS_OFF_WAIT: begin
          if (cnt_r == 32'h0)
            st_r <= HS_OFF;
          else
            cnt_r <= cnt_r - 32'h1;
        end
        HS_OFF:  st_r <= HS_OFF;
        default: st_r <= HS_RST;
      endcase
    end
  end

  // byte engine: one unit is a byte, a nibble or a serial bit
  always_ff @(posedge mclk) begin
    if (reset) begin
      eng_r <= E_IDLE;
      sh_r <= 8'h00;
      unit_r <= 3'h0;
      ph_r <= 2'h0;
      cd_r <= lhb_pkg::CD_CMD;
    end else begin
      case (eng_r)
        E_IDLE: begin
          if (go_r) begin
            eng_r <= E_LO;
            sh_r <= go_byte_r;
            cd_r <= go_cd_r;
            unit_r <= 3'h0;
            ph_r <= 2'h0;
          end
        end
        E_LO: begin
          ph_r <= ph_r + 2'h1;
          // shift a cycle late so the strobe edge still sees the unit
          if (ph_r == 2'h0 && unit_r != 3'h0)
            sh_r <= (mode == lhb_pkg::LHB_SER4) ? {sh_r[6:0], 1'h0}
                                                : {sh_r[3:0], 4'h0};
          if (ph_end)
            eng_r <= E_HI;
        end
        E_HI: begin
          ph_r <= ph_r + 2'h1;
          if (ph_end && unit_r == last_unit) begin
            eng_r <= E_END;
          end else if (ph_end) begin
            eng_r <= E_LO;
            unit_r <= unit_r + 3'h1;
          end
        end
        E_END: begin
          ph_r <= ph_r + 2'h1;
          if (ph_end)
            eng_r <= E_IDLE;
        end
        default: eng_r <= E_IDLE;
      endcase
    end
  end

  // pin levels; unsupported modes never select the module
  always_comb begin
    cs_n_nxt = (eng_r == E_IDLE) || (mode > lhb_pkg::LHB_SER4);
    wr_nxt = 1'h0;
    rd_nxt = 1'h0;
    data_nxt = 8'h00;
    case (mode)
      lhb_pkg::LHB_I80_8, lhb_pkg::LHB_I80_4: begin
        wr_nxt = ~active;
        rd_nxt = 1'h1;
      end
      lhb_pkg::LHB_M68_8, lhb_pkg::LHB_M68_4: begin
        wr_nxt = (eng_r == E_IDLE);
        rd_nxt = active;
      end
      default: begin
        wr_nxt = 1'h0;
        rd_nxt = 1'h0;
      end
    endcase
    case (mode)
      lhb_pkg::LHB_I80_8, lhb_pkg::LHB_M68_8: data_nxt = sh_r;
      lhb_pkg::LHB_I80_4, lhb_pkg::LHB_M68_4: data_nxt = {4'h0, sh_r[7:4]};
      lhb_pkg::LHB_SER4: data_nxt = {4'h0, sh_r[7], 2'h0, active};
      default:           data_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      style_r <= 1'h0;
      width_r <= 2'h0;
      cs_n_r <= 1'h1;
      wr_pin_r <= 1'h1;
      rd_pin_r <= 1'h1;
      data_r <= 8'h00;
    end else begin
      style_r <= style_sel;
      width_r <= width_sel;
      cs_n_r <= cs_n_nxt;
      wr_pin_r <= wr_nxt;
      rd_pin_r <= rd_nxt;
      data_r <= data_nxt;
    end
  end

  assign bus.bus_style_strap = style_r;
  assign bus.width_strap = width_r;
  assign bus.chip_select_primary_n = cs_n_r;
  assign bus.command_data_select = cd_r;
  assign bus.write_strobe_pin = wr_pin_r;
  assign bus.read_strobe_pin = rd_pin_r;
  assign bus.data_bus = data_r;
  assign bus.reset_pin_n = rst_pin_n_r;

  assign wr_ready = (st_r == HS_READY) && eng_free && !power_down_req;
  assign init_done = (st_r == HS_READY);
  assign power_off_ok = (st_r == HS_OFF);

endmodule

/* lhb_asserts.sv */
`timescale 1ns/1ps
module lhb_asserts #(
  parameter int INIT_WAIT_CYC = lhb_pkg::INIT_WAIT_CYC
) (
  input wire logic       mclk,
  input wire logic       reset,
  input wire logic       bus_style_strap,
  input wire logic [1:0] width_strap,
  input wire logic       chip_select_primary_n,
  input wire logic       command_data_select,
  input wire logic       write_strobe_pin,
  input wire logic       read_strobe_pin,
  input wire logic [7:0] data_bus,
  input wire logic       reset_pin_n
);
  logic [31:0] quiet_r;
  logic        par_w;
  logic        i80_w;
  assign par_w = !width_strap[1];
  assign i80_w = par_w && !bus_style_strap;
  // saturates so later bytes never wrap into a false hit
  always_ff @(posedge mclk) begin
    if (reset || !reset_pin_n)
      quiet_r <= 32'h00000000;
    else if (quiet_r != 32'hFFFFFFFF)
      quiet_r <= quiet_r + 32'h00000001;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  property p_rst_quiet;
    !reset_pin_n |-> chip_select_primary_n;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet)
    else $error("select during reset pin");
  property p_wait;
    $fell(chip_select_primary_n) |-> quiet_r >= INIT_WAIT_CYC;
  endproperty
  a_wait: assert property (p_wait)
    else $error("first byte too early");
  property p_cd;
    !chip_select_primary_n && !$past(chip_select_primary_n)
      |-> $stable(command_data_select);
  endproperty
  a_cd: assert property (p_cd)
    else $error("cd moved inside transfer");
  property p_nosel;
    bus_style_strap && width_strap[1] |-> chip_select_primary_n;
  endproperty
  a_nosel: assert property (p_nosel)
    else $error("select in unsupported serial mode");
  property p_rd_idle;
    i80_w[*3] |-> read_strobe_pin;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read strobe active in write path");
  property p_ser;
    (!bus_style_strap && width_strap == 2'h2)[*3]
      |-> !write_strobe_pin && !read_strobe_pin;
  endproperty
  a_ser: assert property (p_ser)
    else $error("strobe not held low in serial");
  property p_nib;
    width_strap == 2'h1 && !chip_select_primary_n
      |-> data_bus[7:4] == 4'h0;
  endproperty
  a_nib: assert property (p_nib)
    else $error("unused data pins not fixed");
  property p_wr;
    i80_w && $fell(write_strobe_pin)
      |-> (!write_strobe_pin)[*4] ##1 write_strobe_pin;
  endproperty
  a_wr: assert property (p_wr)
    else $error("write strobe width wrong");
  property p_hold;
    i80_w && !write_strobe_pin && !$past(write_strobe_pin)
      |-> $stable(data_bus);
  endproperty
  a_hold: assert property (p_hold)
    else $error("data moved under strobe");
  property p_m68;
    (bus_style_strap && par_w)[*3] ##0 read_strobe_pin
      |-> !write_strobe_pin && !chip_select_primary_n;
  endproperty
  a_m68: assert property (p_m68)
    else $error("enable without write select");
endmodule

/* testbench.sv */
`timescale 1ns/1ps
module testbench;
  localparam int IWAIT = 50;
  localparam int OWAIT = 20;
  logic                mclk;
  logic                reset;
  logic                style_sel;
  logic [1:0]          width_sel;
  logic [7:0]          contrast_level;
  logic                wr_valid;
  logic [7:0]          wr_data;
  logic                wr_ready;
  logic                power_down_req;
  logic                init_done;
  logic                power_off_ok;
  lhb_pkg::lhb_mode_t  mode;
  logic                mode_ok;
  logic [1:0]          temp_comp_field;
  logic [3:0]          pump_panel_field;
  logic [2:0]          mapping_field;
  logic [6:0]          line_inversion_field;
  logic [1:0]          bias_ratio_field;
  logic [7:0]          contrast_level_field;
  logic [5:0]          display_control_field;
  logic [7:0]          disp_data;
  logic                disp_valid;
  int                  fails;
  int                  checked;
  int                  n;
  lhb_pkg::lhb_mode_t  md_tab [8] = '{lhb_pkg::LHB_I80_8,
    lhb_pkg::LHB_I80_4, lhb_pkg::LHB_M68_8, lhb_pkg::LHB_M68_4,
    lhb_pkg::LHB_SER4, lhb_pkg::LHB_SER3, lhb_pkg::LHB_I2C,
    lhb_pkg::LHB_BADMODE};
  // straps per test, bit i and bits 2i+1:2i
  logic [7:0]          st_tab = 8'h6C;
  logic [15:0]         wd_tab = 16'hFA44;

  lhb_if lhb_if_inst ();
  lhb_host #(.INIT_WAIT_CYC(IWAIT), .OFF_WAIT_CYC(OWAIT)) lhb_host_inst (
    .mclk(mclk), .reset(reset), .bus(lhb_if_inst.host),
    .style_sel(style_sel), .width_sel(width_sel),
    .contrast_level(contrast_level), .wr_valid(wr_valid),
    .wr_data(wr_data), .wr_ready(wr_ready),
    .power_down_req(power_down_req), .init_done(init_done),
    .power_off_ok(power_off_ok));
  lhb_device lhb_device_inst (
    .mclk(mclk), .reset(reset), .bus(lhb_if_inst.device),
    .mode(mode), .mode_ok(mode_ok), .temp_comp_field(temp_comp_field),
    .pump_panel_field(pump_panel_field), .mapping_field(mapping_field),
    .line_inversion_field(line_inversion_field),
    .bias_ratio_field(bias_ratio_field),
    .contrast_level_field(contrast_level_field),
    .display_control_field(display_control_field),
    .disp_data(disp_data), .disp_valid(disp_valid));
  lhb_asserts #(.INIT_WAIT_CYC(IWAIT)) lhb_asserts_inst (
    .mclk(mclk), .reset(reset),
    .bus_style_strap(lhb_if_inst.bus_style_strap),
    .width_strap(lhb_if_inst.width_strap),
    .chip_select_primary_n(lhb_if_inst.chip_select_primary_n),
    .command_data_select(lhb_if_inst.command_data_select),
    .write_strobe_pin(lhb_if_inst.write_strobe_pin),
    .read_strobe_pin(lhb_if_inst.read_strobe_pin),
    .data_bus(lhb_if_inst.data_bus),
    .reset_pin_n(lhb_if_inst.reset_pin_n));

  always #2 mclk = ~mclk;

  task automatic chk(input string nm, input logic [7:0] seen,
                     input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // 0 init_done, 1 power_off_ok, 2 disp_valid, 3 wr_ready
  task automatic wait_sig(input int which, input int lim, output int k);
    logic s;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
      s = which == 0 ? init_done : which == 1 ? power_off_ok :
          which == 2 ? disp_valid : wr_ready;
    end while (s !== 1'b1 && k < lim);
    chk("wait", 8'(s), 8'h01);
  endtask

  task automatic do_reset(input logic st, input logic [1:0] wd,
                          input logic [7:0] ct);
    reset <= 1'b1;
    style_sel <= st;
    width_sel <= wd;
    contrast_level <= ct;
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
  endtask

  // request held until the edge that samples ready high
  task automatic send(input logic [7:0] d);
    int k;
    wr_valid <= 1'b1;
    wr_data <= d;
    wait_sig(3, 500, k);
    wr_valid <= 1'b0;
    wait_sig(2, 500, k);
    chk("disp_data", disp_data, d);
  endtask

  initial begin
    mclk = 1'b0;
    reset = 1'b1;
    style_sel = 1'b0;
    width_sel = 2'h0;
    contrast_level = 8'h00;
    wr_valid = 1'b0;
    wr_data = 8'h00;
    power_down_req = 1'b0;
    fails = 0;
    checked = 0;
    @(posedge mclk);
    for (int i = 0; i < 8; i++) begin
      do_reset(st_tab[i], wd_tab[2*i +: 2], 8'hDC - 8'(i * 8));
      if (i < 5)
        wait_sig(0, 3000, n);
      else
        repeat (1500) @(posedge mclk);
      chk("mode", 8'(mode), 8'(md_tab[i]));
      chk("mode_ok", 8'(mode_ok), 8'(i < 5));
      if (i < 5) begin
        chk("temp", 8'(temp_comp_field), 8'h02);
        chk("pump", 8'(pump_panel_field), 8'h0F);
        chk("map", 8'(mapping_field), 8'h04);
        chk("inv", 8'(line_inversion_field), 8'h08);
        chk("bias", 8'(bias_ratio_field), 8'h02);
        chk("pm", contrast_level_field, 8'hDC - 8'(i * 8));
        chk("dc", 8'(display_control_field), 8'h09);
        send(8'h3C ^ 8'(i));
        send(8'hC3);
      end else
        chk("pm", contrast_level_field, 8'h00);
      $display("test mode %0d done", i);
    end
    do_reset(1'b0, 2'h0, 8'hDC);
    wait_sig(0, 3000, n);
    power_down_req <= 1'b1;
    wait_sig(1, 500, n);
    chk("off_wait", 8'(n > OWAIT), 8'h01);
    chk("pm_off", contrast_level_field, 8'h00);
    chk("dc_off", 8'(display_control_field), 8'h00);
    chk("ready_off", 8'(wr_ready), 8'h00);
    $display("test power off done");
    end_of_test();
  end

  // all tests need about 7200 cycles
  initial begin
    repeat (60000) @(posedge mclk);
    fails++;
    $display("[ERR] watchdog exp done seen hang");
    end_of_test();
  end
endmodule
